/* File: hdl/dcs_pkg.sv */
package dcs_pkg;
  // register byte addresses
  localparam logic [3:0] ADDR_SELR   = 4'h0;
  localparam logic [3:0] ADDR_CMDR   = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  // clock selection register layout
  localparam int SRC_LSB  = 0;
  localparam int SRC_W    = 4;
  localparam int GAIN_W   = 3;
  localparam int SUT_LSB  = 4;
  localparam int SUT_W    = 2;
  localparam int XTAL_BIT = 3;
  // clock command register layout
  localparam int CMD_W    = 4;
  localparam int CE_BIT   = 7;
  localparam logic [7:0] CE_ONLY = 8'h80;
  // command codes
  localparam logic [3:0] CMD_NONE    = 4'h0;
  localparam logic [3:0] CMD_DISABLE = 4'h1;
  localparam logic [3:0] CMD_ENABLE  = 4'h2;
  localparam logic [3:0] CMD_SWITCH  = 4'h4;
  localparam logic [3:0] CMD_RECOVER = 4'h8;
  // unlock window length
  localparam int UNLOCK_CYC = 4;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // reset values
  localparam logic [3:0] RST_SRC = 4'h0;
  localparam logic [1:0] RST_SUT = 2'h2;
endpackage

/* File: hdl/dcs_ctrl.sv */
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
// How it works
// - the crystal gain output follows the low three source-select bits.
// - a recover command restores the top select bit, never the low three.
// - every selection write with byte strobe 0 set moves the crystal gain at once, whatever runs.
// - codes 0001 disable, 0010 enable, 0100 switch the selected source.
// - a disable command stays active after it has stopped its source.
// - while disable lingers, any newly selected source is stopped as well.
module dcs_ctrl #(
  parameter int NSRC = 16
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst,
  input  wire logic [3:0]        i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [3:0]        i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  output logic [NSRC-1:0]        o_src_enable,
  output logic [3:0]             o_sys_src,
  output logic [2:0]             o_xtal_gain
);

  // bus state
  logic                 aw_got_ff, nxt_aw_got;
  logic                 w_got_ff, nxt_w_got;
  logic [3:0]           waddr_ff, nxt_waddr;
  logic [7:0]           wbyte_ff, nxt_wbyte;
  logic                 wstb_ff, nxt_wstb;
  logic                 bvalid_ff, nxt_bvalid;
  logic [1:0]           bresp_ff, nxt_bresp;
  logic                 rvalid_ff, nxt_rvalid;
  logic [1:0]           rresp_ff, nxt_rresp;
  logic [31:0]          rdata_ff, nxt_rdata;
  // clock control state
  logic [3:0]           src_ff, nxt_src;
  logic [1:0]           sut_ff, nxt_sut;
  logic [3:0]           cmd_ff, nxt_cmd;
  logic                 unlock_ff, nxt_unlock;
  logic [2:0]           ucnt_ff, nxt_ucnt;
  logic [NSRC-1:0]      en_ff, nxt_en;
  logic [3:0]           sys_ff, nxt_sys;
  logic                 do_write;
  logic [NSRC-1:0]      sel_onehot;

  localparam logic [2:0] UNLOCK_LAST = 3'(dcs_pkg::UNLOCK_CYC - 1);

  assign o_awready = !aw_got_ff && !bvalid_ff;
  assign o_wready  = !w_got_ff && !bvalid_ff;
  assign o_arready = !rvalid_ff;
  assign o_bvalid  = bvalid_ff;
  assign o_bresp   = bresp_ff;
  assign o_rvalid  = rvalid_ff;
  assign o_rresp   = rresp_ff;
  assign o_rdata   = rdata_ff;
  assign do_write  = aw_got_ff && w_got_ff && !bvalid_ff;

  // enable outputs, one per source code
  assign o_src_enable = en_ff;
  assign o_sys_src    = sys_ff;
  assign o_xtal_gain  = src_ff[dcs_pkg::GAIN_W-1:0];

  // decode of the currently selected source
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_sel
      assign sel_onehot[g] = (src_ff == 4'(g));
    end
  endgenerate

  // write channel capture and response
  always_comb begin
    nxt_aw_got = aw_got_ff;
    nxt_w_got  = w_got_ff;
    nxt_waddr  = waddr_ff;
    nxt_wbyte  = wbyte_ff;
    nxt_wstb   = wstb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp  = bresp_ff;
    if (i_awvalid && o_awready) begin
      nxt_aw_got = 1'b1;
      nxt_waddr  = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      nxt_w_got = 1'b1;
      nxt_wbyte = i_wdata[7:0];
      nxt_wstb  = i_wstrb[0];
    end
    if (do_write) begin
      nxt_aw_got = 1'b0;
      nxt_w_got  = 1'b0;
      nxt_bvalid = 1'b1;
      case (waddr_ff)
        dcs_pkg::ADDR_SELR,
        dcs_pkg::ADDR_CMDR,
        dcs_pkg::ADDR_STATUS: nxt_bresp = dcs_pkg::RESP_OKAY;
        default:              nxt_bresp = dcs_pkg::RESP_SLVERR;
      endcase
    end else if (bvalid_ff && i_bready) begin
      nxt_bvalid = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      waddr_ff  <= 4'h0;
      wbyte_ff  <= 8'h00;
      wstb_ff   <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= 2'h0;
    end else begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff  <= nxt_w_got;
      waddr_ff  <= nxt_waddr;
      wbyte_ff  <= nxt_wbyte;
      wstb_ff   <= nxt_wstb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff  <= nxt_bresp;
    end
  end

  // read channel
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rresp  = rresp_ff;
    nxt_rdata  = rdata_ff;
    if (i_arvalid && o_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = dcs_pkg::RESP_OKAY;
      case (i_araddr)
        dcs_pkg::ADDR_SELR:   nxt_rdata = {26'h0, sut_ff, src_ff};
        dcs_pkg::ADDR_CMDR:   nxt_rdata = {24'h0, unlock_ff, 3'h0, cmd_ff};
        dcs_pkg::ADDR_STATUS: nxt_rdata = {16'h0, 4'h0, sys_ff,
                                           1'b0, o_xtal_gain, 4'h0};
        default: begin
          nxt_rdata = 32'h0;
          nxt_rresp = dcs_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && i_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= 2'h0;
      rdata_ff  <= 32'h0;
    end else begin
      rvalid_ff <= nxt_rvalid;
      rresp_ff  <= nxt_rresp;
      rdata_ff  <= nxt_rdata;
    end
  end

  // selection, command, unlock and source control
  always_comb begin
    nxt_src    = src_ff;
    nxt_sut    = sut_ff;
    nxt_cmd    = cmd_ff;
    nxt_unlock = unlock_ff;
    nxt_ucnt   = ucnt_ff;
    nxt_en     = en_ff;
    nxt_sys    = sys_ff;
    if (unlock_ff) begin
      if (ucnt_ff == UNLOCK_LAST) begin
        nxt_unlock = 1'b0;
      end else begin
        nxt_ucnt = ucnt_ff + 3'h1;
      end
    end
    // command execution on the selected source
    case (cmd_ff)
      dcs_pkg::CMD_DISABLE: begin
        nxt_en = en_ff & ~sel_onehot;
      end
      dcs_pkg::CMD_ENABLE: begin
        nxt_en  = en_ff | sel_onehot;
        nxt_cmd = dcs_pkg::CMD_NONE;
      end
      dcs_pkg::CMD_SWITCH: begin
        nxt_sys = src_ff;
        nxt_cmd = dcs_pkg::CMD_NONE;
      end
      dcs_pkg::CMD_RECOVER: begin
        nxt_src[dcs_pkg::XTAL_BIT] = sys_ff[dcs_pkg::XTAL_BIT];
        nxt_cmd = dcs_pkg::CMD_NONE;
      end
      default: nxt_cmd = dcs_pkg::CMD_NONE;
    endcase
    if (do_write && wstb_ff) begin
      if (waddr_ff == dcs_pkg::ADDR_SELR) begin
        nxt_src = wbyte_ff[dcs_pkg::SRC_LSB +: dcs_pkg::SRC_W];
        nxt_sut = wbyte_ff[dcs_pkg::SUT_LSB +: dcs_pkg::SUT_W];
      end else if (waddr_ff == dcs_pkg::ADDR_CMDR) begin
        if (wbyte_ff == dcs_pkg::CE_ONLY) begin
          nxt_unlock = 1'b1;
          nxt_ucnt   = 3'h0;
          nxt_cmd    = dcs_pkg::CMD_NONE;
        end else if (unlock_ff && !wbyte_ff[dcs_pkg::CE_BIT]) begin
          nxt_cmd    = wbyte_ff[dcs_pkg::CMD_W-1:0];
          nxt_unlock = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      src_ff    <= dcs_pkg::RST_SRC;
      sut_ff    <= dcs_pkg::RST_SUT;
      cmd_ff    <= dcs_pkg::CMD_NONE;
      unlock_ff <= 1'b0;
      ucnt_ff   <= 3'h0;
      en_ff     <= NSRC'(1) << dcs_pkg::RST_SRC;
      sys_ff    <= dcs_pkg::RST_SRC;
    end else begin
      src_ff    <= nxt_src;
      sut_ff    <= nxt_sut;
      cmd_ff    <= nxt_cmd;
      unlock_ff <= nxt_unlock;
      ucnt_ff   <= nxt_ucnt;
      en_ff     <= nxt_en;
      sys_ff    <= nxt_sys;
    end
  end

endmodule

/* File: verif/dcs_ctrl_assertions.sv */
`timescale 1ns/1ps
module dcs_ctrl_assertions #(
  parameter int NSRC = 16
) (
  input wire logic            i_ref_clk,
  input wire logic            i_rst,
  input wire logic            i_awvalid,
  input wire logic            o_awready,
  input wire logic            i_wvalid,
  input wire logic            o_wready,
  input wire logic            o_bvalid,
  input wire logic            i_arvalid,
  input wire logic            o_arready,
  input wire logic            o_rvalid,
  input wire logic [NSRC-1:0] o_src_enable,
  input wire logic [3:0]      o_sys_src,
  input wire logic [2:0]      o_xtal_gain
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // both write channels taken, answer two edges on
  sequence s_wr_take;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence s_wr_answer;
    ##2 o_bvalid;
  endsequence
  a_wr_answer: assert property (s_wr_take |-> s_wr_answer)
    else $error("write answer late");
  a_rd_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  a_rd_block: assert property (o_rvalid |-> !o_arready)
    else $error("read taken while busy");
  a_b_block: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken while busy");
  a_gain_cause: assert property (
    $changed(o_xtal_gain) |-> $rose(o_bvalid))
    else $error("gain moved without write");
  a_src_cause: assert property (
    $changed(o_src_enable) |-> o_bvalid || $past(o_bvalid))
    else $error("source enable moved without write");
  a_sys_cause: assert property (
    $changed(o_sys_src) |-> o_bvalid || $past(o_bvalid))
    else $error("system source moved without write");
endmodule

/* File: verif/dynamic_clock_switch_control_tb.sv */
`timescale 1ns/1ps
`define CHK(a,b) begin samples_checked++; if ((a)!==(b)) begin mismatches++; \
  $display("Error %0t: got %h exp %h", $time, a, b); end end
module dynamic_clock_switch_control_tb;
  logic        clk = 0, rst = 1, awv = 0, wv = 0, arv = 0;
  logic [3:0]  awa = 0, ara = 0, sys;
  logic [31:0] wd = 0, rdat;
  logic        awr, wrdy, bv, arr, rv;
  logic [1:0]  bresp, rresp;
  logic [15:0] src;
  logic [2:0]  gain;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          mismatches = 0, samples_checked = 0;
  dcs_ctrl uut (.i_ref_clk(clk), .i_rst(rst), .i_awaddr(awa),
    .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hF),
    .i_wvalid(wv), .o_wready(wrdy), .o_bresp(bresp), .o_bvalid(bv),
    .i_bready(1'b1), .i_araddr(ara), .i_arvalid(arv), .o_arready(arr),
    .o_rdata(rdat), .o_rresp(rresp), .o_rvalid(rv), .i_rready(1'b1),
    .o_src_enable(src), .o_sys_src(sys), .o_xtal_gain(gain));
  initial forever #2.5 clk = ~clk;
  // watcher takes the oldest note per answer
  always @(posedge clk) begin
    if (rv) `CHK({rresp, rdat}, rq.pop_front())
    if (bv) `CHK(bresp, bq.pop_front())
  end
  task print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    input logic [1:0] e = 2'h0);
    int n = 0;
    bq.push_back(e);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1;
    wv <= 1;
    do begin
      @(posedge clk);
      n++;
      if (awr) awv <= 0;
      if (wrdy) wv <= 0;
    end while (!bv && n < 20);
    if (n >= 20) begin mismatches++; print_verdict; end
  endtask
  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    int n = 0;
    rq.push_back(e);
    ara <= a;
    arv <= 1;
    do begin
      @(posedge clk);
      n++;
      if (arr) arv <= 0;
    end while (!rv && n < 20);
    if (n >= 20) begin mismatches++; print_verdict; end
  endtask
  // unlock then command, back to back
  task automatic cmd(input logic [7:0] c);
    wr(4'h4, 8'h80);
    wr(4'h4, c);
    repeat (2) @(posedge clk);
  endtask
  initial begin
    logic [7:0] d;
    void'($urandom(96));
    repeat (2) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    `CHK(src, 16'h0001)
    `CHK(gain, 3'h0)
    rd(4'h0, 34'h20);
    rd(4'hC, {2'h2, 32'h0});
    wr(4'hC, 8'h00, 2'h2);
    $display("test reset done");
    // random selections move the gain at once
    repeat (4) begin
      d = 8'($urandom) & 8'h3F;
      wr(4'h0, d);
      `CHK(gain, d[2:0])
      rd(4'h0, {28'h0, d[5:0]});
      rd(4'h8, {27'h0, d[2:0], 4'h0});
    end
    wr(4'h0, 8'h2F);
    `CHK(gain, 3'h7)
    $display("test gain done");
    wr(4'h0, 8'h0F);
    wr(4'h4, 8'h02);
    repeat (2) @(posedge clk);
    `CHK(src, 16'h0001)
    cmd(8'h02);
    `CHK(src, 16'h8001)
    cmd(8'h04);
    `CHK(sys, 4'hF)
    wr(4'h0, 8'h03);
    wr(4'h4, 8'h80);
    repeat (6) @(posedge clk);
    wr(4'h4, 8'h02);
    repeat (2) @(posedge clk);
    `CHK(src, 16'h8001)
    cmd(8'h02);
    wr(4'h0, 8'h05);
    cmd(8'h02);
    `CHK(src, 16'h8029)
    wr(4'h0, 8'h03);
    cmd(8'h01);
    `CHK(src, 16'h8021)
    wr(4'h0, 8'h05);
    repeat (2) @(posedge clk);
    `CHK(src, 16'h8001)
    wr(4'h4, 8'h80);
    wr(4'h0, 8'h03);
    cmd(8'h02);
    `CHK(src, 16'h8009)
    $display("test commands done");
    wr(4'h0, 8'h01);
    cmd(8'h08);
    rd(4'h0, 34'h09);
    `CHK(gain, 3'h1)
    $display("test recover done");
    print_verdict;
  end
endmodule
bind dcs_ctrl dcs_ctrl_assertions #(.NSRC(NSRC)) u_chk (
  .i_ref_clk    (i_ref_clk),
  .i_rst        (i_rst),
  .i_awvalid    (i_awvalid),
  .o_awready    (o_awready),
  .i_wvalid     (i_wvalid),
  .o_wready     (o_wready),
  .o_bvalid     (o_bvalid),
  .i_arvalid    (i_arvalid),
  .o_arready    (o_arready),
  .o_rvalid     (o_rvalid),
  .o_src_enable (o_src_enable),
  .o_sys_src    (o_sys_src),
  .o_xtal_gain  (o_xtal_gain)
);
